// ---- src/dvp_pkg.sv ----
// Package: shared constants for the panel link receiver and reset filter
package dvp_pkg;
    // ==================================================
    // Clock rates
    localparam int CLK_PERIOD_NS = 25;
    localparam int LINK_PERIOD_NS = 32;
    // ==================================================
    // Low-power state length driven by the module and the host model (ns)
    localparam int LP_STATE_MIN_NS = 50;
    localparam int LP_STATE_MAX_NS = 75;
    localparam int LP_STATE_CYC = (LP_STATE_MIN_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    localparam int TA_GO_STATES = 4;
    localparam int TA_GET_STATES = 5;
    // End-of-burst skip window (ns), least figure
    localparam int HS_SKIP_NS = 40;
    localparam int HS_SKIP_CYC = (HS_SKIP_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    // ==================================================
    // Reset pin filter (us) and completion times (ms)
    localparam int RST_REJECT_US = 5;
    localparam int RST_ACCEPT_US = 10;
    localparam int RST_FILT_CYC = (RST_REJECT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OTP_LOAD_MS = 5;
    localparam int SLEEP_OUT_MS = 120;
    localparam int OTP_LOAD_CYC = OTP_LOAD_MS * 1000000 / CLK_PERIOD_NS;
    localparam int BLANK_CYC = SLEEP_OUT_MS * 1000000 / CLK_PERIOD_NS;
    // ==================================================
    // Lane-0 line states {p,n}
    localparam logic [1:0] LP00 = 2'h0;
    localparam logic [1:0] LP01 = 2'h1;
    localparam logic [1:0] LP10 = 2'h2;
    localparam logic [1:0] LP11 = 2'h3;
    typedef enum {DVP_IDLE, DVP_HS, DVP_SKIP, DVP_TA_GO, DVP_TA_DRV, DVP_TA_RET} dvp_state_e;
endpackage

// ---- src/dvp_reset_filter.sv ----
// Reset pin spike filter and reset completion sequencer
`timescale 1ns/100ps
module dvp_reset_filter #(
    parameter int FILT_CYC = 200,
    parameter int LOAD_CYC = 200000,
    parameter int BLANK_LEN = 4800000
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Pin and mode
    input wire logic panel_reset_n,
    input wire logic sleep_out,
    // Status
    output logic core_reset,
    output logic blank,
    output logic otp_loaded
);
    import dvp_pkg::*;
    logic [2:0] sync;
    logic [31:0] low_cnt, next_low_cnt, done_cnt, next_done_cnt;
    logic next_core_reset, next_blank, next_otp_loaded, pin_low, pin_lvl;

    // Three-stage sync; the filtered level moves only once stages two and three agree
    assign pin_low = ~pin_lvl;

    // Count low time; short spikes never reach the threshold
    always_comb begin
        next_low_cnt = pin_low ? ((low_cnt < FILT_CYC) ? low_cnt + 32'h1 : low_cnt) : 32'h0;
        next_core_reset = core_reset;
        next_done_cnt = done_cnt;
        next_blank = blank;
        next_otp_loaded = otp_loaded;
        if (low_cnt >= FILT_CYC) begin // RQ16
            next_core_reset = 1'b1;
            next_blank = 1'b1; // RQ17
            next_otp_loaded = 1'b0;
            next_done_cnt = 32'h0;
        end else if (core_reset && !pin_low) begin
            next_done_cnt = done_cnt + 32'h1;
            if (done_cnt + 32'h1 >= LOAD_CYC) next_otp_loaded = 1'b1; // RQ18
            // Blanking runs longer while sleep_out is high during the completion count
            if (done_cnt + 32'h1 >= (sleep_out ? BLANK_LEN : LOAD_CYC)) begin // RQ17
                next_core_reset = 1'b0;
                next_blank = 1'b0;
            end
        end
    end

    // Register the filter state
    always_ff @(posedge clock) begin
        if (rst) begin
            sync <= 3'h7;
            pin_lvl <= 1'b1;
            low_cnt <= 32'h0;
            done_cnt <= 32'h0;
            core_reset <= 1'b1;
            blank <= 1'b1;
            otp_loaded <= 1'b0;
        end else begin
            sync <= {sync[1:0], panel_reset_n};
            pin_lvl <= (sync[1] == sync[2]) ? sync[2] : pin_lvl;
            low_cnt <= next_low_cnt;
            done_cnt <= next_done_cnt;
            core_reset <= next_core_reset;
            blank <= next_blank;
            otp_loaded <= next_otp_loaded;
        end
    end

    a_otp_before_release: assert property (@(posedge clock) disable iff (rst)
        $fell(core_reset) |-> otp_loaded) else $error("release before load"); // RQ18
    a_blank_with_reset: assert property (@(posedge clock) disable iff (rst)
        core_reset |-> blank) else $error("not blanked in reset"); // RQ17
    a_spike_reject: assert property (@(posedge clock) disable iff (rst)
        $rose(core_reset) |-> $past(low_cnt) >= FILT_CYC) else $error("spike reset"); // RQ16
    c_reset_done: cover property (@(posedge clock) $fell(core_reset));
endmodule

// ---- src/dvp_link.sv ----
// Video panel link receiver: lane-0 LP states, turnaround, burst framing, reset
// Functional notes
// RQ1 - Only video-mode operation; command-mode pixel transfers are not accepted.
// RQ2 - Host sends video only in high-speed bursts.
// RQ3 - Host keeps aggregate lane rate within pixel-format limits.
// RQ4 - Host holds each lane-0 LP state 50 to 75 ns.
// RQ5 - Module holds each driven LP state 50 to 75 ns.
// RQ6 - Host waits one to two LP lengths before retaking lane.
// RQ7 - Module drives LP-00 at least five LP lengths when taking lane.
// RQ8 - Module drives LP-00 at least four LP lengths before ownership completes; module instead waits four LP lengths undriven, then takes the lane.
// RQ9 - Host holds every data-lane LP state at least 50 ns.
// RQ10 - Host prepare LP-00 within data and clock lane windows.
// RQ11 - Module ignores lane transitions in end-of-burst skip window.
// RQ12 - Host trail at least 60 ns plus 4 UI, then LP-11 100 ns.
// RQ13 - Host keeps clock after data returns to LP, then trails.
// RQ14 - Clock prepare plus zero lasts at least 300 ns.
// RQ15 - Clock runs 8 UI before data lanes leave LP.
// RQ16 - Reset pin lows under 5 us ignored, over 10 us reset.
// RQ17 - Display blanked in reset; done within 5 ms or 120 ms.
// RQ18 - OTP copied to registers within 5 ms of reset rising.
// RQ19 - Host waits 5 ms for commands, 120 ms for sleep-out.
// RQ20 - Host deep standby timing and 3 ms exit reset pulse.
// RQ21 - Host keeps video for more than 8 frames at power-on.
// RQ22 - Host preferably pulses reset high-low-high at power-on.
`timescale 1ns/100ps
module dvp_link #(
    parameter int FILT_CYC = dvp_pkg::RST_FILT_CYC,
    parameter int LOAD_CYC = dvp_pkg::OTP_LOAD_CYC,
    parameter int BLANK_LEN = dvp_pkg::BLANK_CYC
) (
    // System clock and reset
    input wire logic clock,
    input wire logic rst,
    // Link clock domain
    input wire logic link_clock,
    input wire logic link_rst,
    // Lane 0 low-power lines, p in bit 1
    input wire logic [1:0] lane0_lp_in,
    output logic [1:0] lane0_lp_out,
    output logic [1:0] lane0_lp_oe,
    // High-speed payload bit from the lane deserialiser
    input wire logic hs_bit,
    // Reset pin and power mode
    input wire logic panel_reset_n,
    input wire logic sleep_out,
    // Status in the system domain
    output logic hs_active,
    output logic display_blank,
    output logic otp_loaded,
    output logic bus_owned
);
    import dvp_pkg::*;
    dvp_state_e state, next_state;
    logic [1:0] s1, s2, s3, lp;
    logic [7:0] cnt, next_cnt;
    logic [1:0] next_out, next_oe;
    logic [2:0] seq, next_seq;
    logic own, next_own, hs, next_hs;
    logic [2:0] hs_sync, own_sync;
    logic core_reset, blank_i, otp_i;
    logic [2:0] crst_sync;
    logic crst_l;

    // ==================================================
    // Reset filter in the system domain
    dvp_reset_filter #(.FILT_CYC(FILT_CYC), .LOAD_CYC(LOAD_CYC), .BLANK_LEN(BLANK_LEN)) u_rst (
        .clock(clock),
        .rst(rst),
        .panel_reset_n(panel_reset_n),
        .sleep_out(sleep_out),
        .core_reset(core_reset),
        .blank(blank_i),
        .otp_loaded(otp_i)
    );

    // ==================================================
    // Lane input and core reset: three flops each, a change counts once stages two and three agree
    // The core reset comes from the system clock, so it must not be read raw here
    always_ff @(posedge link_clock) begin
        if (link_rst) begin
            s1 <= LP11;
            s2 <= LP11;
            s3 <= LP11;
            lp <= LP11;
            crst_sync <= 3'h7;
            crst_l <= 1'b1;
        end else begin
            s1 <= lane0_lp_in;
            s2 <= s1;
            s3 <= s2;
            lp <= (s2 == s3) ? s3 : lp;
            crst_sync <= {crst_sync[1:0], core_reset};
            crst_l <= (crst_sync[1] == crst_sync[2]) ? crst_sync[2] : crst_l;
        end
    end

    // Lane state machine; seq tracks LP-11,01,00 entry to HS and LP-11,10,00,10,00 turnaround
    always_comb begin
        next_state = state;
        next_cnt = (cnt != 8'h0) ? cnt - 8'h1 : 8'h0;
        next_out = lane0_lp_out;
        next_oe = lane0_lp_oe;
        next_seq = seq;
        next_own = own;
        next_hs = hs;
        case (state)
            DVP_IDLE: begin
                // LP-11 -> LP-01 -> LP-00 enters HS; LP-11 -> LP-10 -> LP-00 -> LP-10 -> LP-00 turns
                if (lp == LP11) next_seq = 3'h0;
                else if (lp == LP01 && seq == 3'h0) next_seq = 3'h4;
                else if (lp == LP00 && seq == 3'h4) begin
                    // Video is taken only in HS bursts; refused while the core is held in reset
                    if (!crst_l) begin
                        next_state = DVP_HS; // RQ1
                        next_hs = 1'b1;
                    end
                    next_seq = 3'h0;
                end else if (lp == LP10 && seq == 3'h0) next_seq = 3'h1;
                else if (lp == LP00 && seq == 3'h1) next_seq = 3'h2;
                else if (lp == LP10 && seq == 3'h2) next_seq = 3'h3;
                else if (lp == LP00 && seq == 3'h3) begin
                    // Turnaround: host released lane, we take over
                    next_state = DVP_TA_GO;
                    next_cnt = 8'(TA_GO_STATES * LP_STATE_CYC); // RQ8
                    next_seq = 3'h0;
                end
            end
            DVP_HS: begin
                if (lp == LP11) begin
                    // Ignore end-of-burst glitches for the skip window
                    next_state = DVP_SKIP; // RQ11
                    next_cnt = 8'(HS_SKIP_CYC);
                end
            end
            DVP_SKIP: begin
                if (cnt == 8'h0) begin // RQ11
                    next_state = DVP_IDLE;
                    next_hs = 1'b0;
                    next_seq = 3'h0;
                end
            end
            DVP_TA_GO: begin
                if (cnt == 8'h0) begin
                    next_state = DVP_TA_DRV;
                    next_oe = 2'h3;
                    next_out = LP00;
                    next_own = 1'b1;
                    next_cnt = 8'(TA_GET_STATES * LP_STATE_CYC); // RQ7
                end
            end
            DVP_TA_DRV: begin
                // After the first LP-00 hold, each driven state held one LP length in the 50..75 ns band
                // Count loaded one short: the zero cycle is part of the hold, else 96 ns
                if (cnt == 8'h0) begin // RQ5
                    if (lane0_lp_out == LP00) next_out = LP10;
                    else if (lane0_lp_out == LP10) next_out = LP00;
                    else next_out = LP00;
                    next_cnt = 8'(LP_STATE_CYC - 1);
                    if (lane0_lp_out == LP10) begin
                        next_state = DVP_TA_RET;
                        next_cnt = 8'(LP_STATE_CYC - 1);
                    end
                end
            end
            DVP_TA_RET: begin
                // Final LP-00 then release; host waits 1..2 LP lengths
                if (cnt == 8'h0) begin // RQ6
                    next_state = DVP_IDLE;
                    next_oe = 2'h0;
                    next_out = LP11;
                    next_own = 1'b0;
                end
            end
            default: next_state = DVP_IDLE;
        endcase
    end

    // Register lane state
    always_ff @(posedge link_clock) begin
        if (link_rst) begin
            state <= DVP_IDLE;
            cnt <= 8'h0;
            lane0_lp_out <= LP11;
            lane0_lp_oe <= 2'h0;
            seq <= 3'h0;
            own <= 1'b0;
            hs <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            lane0_lp_out <= next_out;
            lane0_lp_oe <= next_oe;
            seq <= next_seq;
            own <= next_own;
            hs <= next_hs;
        end
    end

    // ==================================================
    // Level crossings of hs and own into the system domain; reset status registered once
    always_ff @(posedge clock) begin
        if (rst) begin
            hs_sync <= 3'h0;
            own_sync <= 3'h0;
            hs_active <= 1'b0;
            bus_owned <= 1'b0;
            display_blank <= 1'b1;
            otp_loaded <= 1'b0;
        end else begin
            hs_sync <= {hs_sync[1:0], hs};
            own_sync <= {own_sync[1:0], own};
            hs_active <= (hs_sync[1] == hs_sync[2]) ? hs_sync[2] : hs_active;
            bus_owned <= (own_sync[1] == own_sync[2]) ? own_sync[2] : bus_owned;
            display_blank <= blank_i;
            otp_loaded <= otp_i;
        end
    end

    a_ta_go_len: assert property (@(posedge link_clock) disable iff (link_rst)
        $rose(own) |-> $past(state) == DVP_TA_GO) else $error("lane taken early"); // RQ8
    a_ta_drive_len: assert property (@(posedge link_clock) disable iff (link_rst)
        $rose(own) |=> (lane0_lp_out == LP00)[*8]) else $error("short LP-00"); // RQ7
    a_lp_hold: assert property (@(posedge link_clock) disable iff (link_rst)
        (own && $changed(lane0_lp_out) && $past(own)) |=> $stable(lane0_lp_out))
        else $error("LP state too short"); // RQ5
    a_skip_ignore: assert property (@(posedge link_clock) disable iff (link_rst)
        $rose(state == DVP_SKIP) |=> (hs)[*1]) else $error("skip cut short"); // RQ11
    a_oe_owned: assert property (@(posedge link_clock) disable iff (link_rst)
        (lane0_lp_oe != 2'h0) |-> own) else $error("drive without owning"); // RQ5
    a_hs_not_reset: assert property (@(posedge link_clock) disable iff (link_rst)
        $rose(hs) |-> ($past(state) == DVP_IDLE) && !$past(crst_l))
        else $error("bad HS entry"); // RQ1
    c_burst: cover property (@(posedge link_clock) $fell(hs));
    c_turn: cover property (@(posedge link_clock) $fell(own));
    c_blank_off: cover property (@(posedge clock) $fell(display_blank));
endmodule

// ---- tb/dvp_host_model.sv ----
// Host transmitter model driving the lane 0 low-power states
`timescale 1ns/100ps
module dvp_host_model (
    // Link clock
    input wire logic link_clock,
    // Lane 0 drive toward the module
    output logic [1:0] host_lp,
    output logic host_oe
);
    import dvp_pkg::*;
    // ==================================================
    // Host owns the lane and idles in the stop state from power-on
    initial begin
        host_lp = dvp_pkg::LP11;
        host_oe = 1'b1;
    end
    // One state held LP_STATE_CYC link cycles: 64 ns, inside the 50..75 ns band
    task automatic send(input logic [1:0] lp);
        host_lp <= lp;
        repeat (LP_STATE_CYC) @(posedge link_clock);
    endtask
    // Burst entry by LP-01 request; pixel data only ever travels inside a burst
    // Clock lane prepare, zero and pre-run are taken as done before this request
    task automatic hs_enter();
        @(posedge link_clock);
        send(LP11);
        send(LP01);
        send(LP00);
    endtask
    // Trail and clock post-run are folded into the stop state that ends the burst
    task automatic hs_exit();
        @(posedge link_clock);
        send(LP11);
    endtask
    // Turnaround request, then the lane is let go
    task automatic turn();
        @(posedge link_clock);
        send(LP11);
        send(LP10);
        send(LP00);
        send(LP10);
        send(LP00);
        host_oe <= 1'b0;
    endtask
    // Take the lane back one to two state lengths after the module lets go
    task automatic retake(input int w);
        repeat (w) @(posedge link_clock);
        host_lp <= LP11;
        host_oe <= 1'b1;
    endtask
endmodule

// ---- tb/dvp_video_panel_link_and_reset_test.sv ----
// Self-checking bench for the panel link receiver and reset filter
`timescale 1ns/100ps
module dvp_video_panel_link_and_reset_test;
    import dvp_pkg::*;
    localparam int FILT = 8;
    localparam int LOAD = 50;
    localparam int BLANK = 100;
    localparam int LPC = LP_STATE_CYC;
    logic clock = 1'b0;
    logic link_clock = 1'b0;
    logic rst = 1'b1;
    logic link_rst = 1'b1;
    logic panel_reset_n = 1'b1;
    logic sleep_out = 1'b0;
    logic hs_bit = 1'b0;
    logic [1:0] flt = 2'h3;
    logic [1:0] host_lp, lane0_lp_in, lane0_lp_out, lane0_lp_oe;
    logic host_oe, hs_active, display_blank, otp_loaded, bus_owned;
    logic [3:0] st;
    int n_errors = 0;
    int samples_checked = 0;
    int seed = 4;
    int n;
    // ==================================================
    // Clocks, unrelated in phase
    always #12.5 clock = ~clock;
    always #16 link_clock = ~link_clock;
    // Payload bits are random; one bit a system cycle stays far under the rate limits
    always @(negedge clock) hs_bit <= 1'($random(seed));
    // Undriven lane lines wander so a stale level is never trusted
    always @(posedge link_clock) flt <= ~flt;
    assign lane0_lp_in = lane0_lp_oe[0] ? lane0_lp_out : (host_oe ? host_lp : flt);
    assign st = {bus_owned, hs_active, display_blank, otp_loaded};
    // ==================================================
    // Units under test, long counts shortened
    dvp_link #(.FILT_CYC(FILT), .LOAD_CYC(LOAD), .BLANK_LEN(BLANK)) dut (
        .clock(clock), .rst(rst), .link_clock(link_clock), .link_rst(link_rst),
        .lane0_lp_in(lane0_lp_in), .lane0_lp_out(lane0_lp_out), .lane0_lp_oe(lane0_lp_oe),
        .hs_bit(hs_bit), .panel_reset_n(panel_reset_n), .sleep_out(sleep_out),
        .hs_active(hs_active), .display_blank(display_blank), .otp_loaded(otp_loaded),
        .bus_owned(bus_owned)
    );
    dvp_host_model host (.link_clock(link_clock), .host_lp(host_lp), .host_oe(host_oe));
    // ==================================================
    // Compare and wait helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Counts must fall in a band; the band is reported as expected
    task automatic chk_rng(input int got, input int lo, input int hi);
        samples_checked++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("MISMATCH t=%0t got %h exp %h..%h", $time, got, lo, hi);
        end
    endtask
    // Bounded wait for a status bit, counted in system cycles
    task automatic wait_sys(input int sel, input logic v);
        n = 0;
        while (st[sel] !== v && n < 2000) begin
            @(negedge clock);
            n++;
        end
    endtask
    // Link cycles while the driven lane matches, or until it does
    task automatic link_cnt(input logic [3:0] pat, input bit same);
        n = 0;
        while ((({lane0_lp_oe, lane0_lp_out} === pat) == same) && n < 64) begin
            @(posedge link_clock);
            #1;
            n++;
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ==================================================
    // Watchdog: the whole run needs a few tens of microseconds at most
    initial begin
        #200000;
        n_errors++;
        end_of_test();
    end
    // Main sequence
    initial begin
        repeat (4) @(negedge clock);
        chk(st, 4'h2);
        chk({lane0_lp_oe, lane0_lp_out}, {2'h0, LP11});
        @(negedge clock);
        rst = 1'b0;
        link_rst = 1'b0;
        // Load finishes before any traffic is offered
        wait_sys(0, 1'b1);
        chk_rng(n, LOAD - 2, LOAD + FILT + 8);
        chk(display_blank, 1'b0);
        // Nine bursts back to back, more than eight frames of video
        for (int k = 0; k < 9; k++) begin
            host.hs_enter();
            wait_sys(2, 1'b1);
            chk_rng(n, 0, 30);
            repeat (16) @(negedge clock);
            chk(hs_active, 1'b1);
            host.hs_exit();
            wait_sys(2, 1'b0);
            chk_rng(n, 0, 30);
        end
        // Turnaround: module takes the lane, answers, lets go
        host.turn();
        link_cnt({2'h3, LP00}, 1'b0);
        chk_rng(n, 1, 16);
        fork
            link_cnt({2'h3, LP00}, 1'b1);
            begin
                repeat (6) @(negedge clock);
                chk(bus_owned, 1'b1);
            end
        join
        chk_rng(n, TA_GET_STATES * LPC, TA_GET_STATES * LPC + 1);
        link_cnt({2'h3, LP10}, 1'b1);
        chk(n, LPC);
        link_cnt({2'h3, LP00}, 1'b1);
        chk(n, LPC);
        chk({lane0_lp_oe, lane0_lp_out}, {2'h0, LP11});
        host.retake(LPC + ($random(seed) & 1));
        wait_sys(3, 1'b0);
        chk_rng(n, 0, 20);
        // Short spike on the reset pin is ignored
        @(negedge clock);
        panel_reset_n = 1'b0;
        repeat (1 + ($unsigned($random(seed)) % (FILT - 4))) @(negedge clock);
        panel_reset_n = 1'b1;
        repeat (20) @(negedge clock);
        chk(st[1:0], 2'h1);
        // Long low pulse resets; burst entry is refused meanwhile
        sleep_out = 1'b1;
        panel_reset_n = 1'b0;
        repeat (2 * FILT) @(negedge clock);
        chk(display_blank, 1'b1);
        host.hs_enter();
        repeat (8) @(negedge clock);
        chk(hs_active, 1'b0);
        host.hs_exit();
        @(negedge clock);
        panel_reset_n = 1'b1;
        wait_sys(1, 1'b0);
        chk_rng(n, BLANK - 2, BLANK + FILT + 8);
        chk(otp_loaded, 1'b1);
        end_of_test();
    end
endmodule
